// File: hdl/hostport_pkg.sv
/*
 * constants and state types shared by both ends of the parallel host port.
 * assumes one 50 mhz clock and a synchronous active-low reset.
 */
`default_nettype none
package hostport_pkg;
    // pin map of the 15-bit port
    localparam int PIN_W = 15;
    localparam int DATA_W = 8;
    localparam int SEL_W = 3;
    localparam int REGS = 8;
    localparam int DATA_LSB = 0;
    localparam int SEL_LSB = 8;
    localparam int DIR_BIT = 11;
    localparam int STB_BIT = 12;
    localparam int REQ_BIT = 13;
    localparam int ACK_BIT = 14;
    // level of an undriven pin: strobe, request and acknowledge pulled high
    localparam logic [PIN_W-1:0] PIN_PULL = 15'h7000;
    // reset values
    localparam logic [PIN_W-1:0] OE_RESET = 15'h0000;
    localparam logic [PIN_W-1:0] OUT_RESET = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
    // host timing in clock cycles
    localparam logic [3:0] SETUP_CYC = 4'h2;
    localparam logic [3:0] STROBE_CYC = 4'h8;
    localparam logic [3:0] HOLD_CYC = 4'h4;
    localparam logic [3:0] CNT_RESET = 4'h0;

    typedef logic [PIN_W-1:0] pins_t;
    typedef logic [DATA_W-1:0] byte_t;
    typedef logic [SEL_W-1:0] sel_t;
    typedef logic [REGS-1:0][DATA_W-1:0] bank_t;

    typedef enum logic [1:0] {st_idle, st_setup, st_strobe, st_hold} host_st_t;
endpackage
`default_nettype wire

// File: hdl/hostport_if.sv
/*
 * the 15 port pins between device end and host end.
 * each side gives output and enable per pin; this resolves the wire level,
 * an undriven pin taking its pull level.
 */
`timescale 1ns/1ps
`default_nettype none
interface hostport_if;
    import hostport_pkg::*;
    // device side drive
    pins_t dev_o;
    pins_t dev_oe;
    // host side drive
    pins_t host_o;
    pins_t host_oe;
    // resolved pin levels
    pins_t pins;

    genvar i;
    generate
        for (i = 0; i < PIN_W; i = i + 1)
        begin : g_pin
            assign pins[i] = dev_oe[i] ? dev_o[i] :
                             host_oe[i] ? host_o[i] : PIN_PULL[i];
        end
    endgenerate

    modport device (output dev_o, output dev_oe, input pins);
    modport host (output host_o, output host_oe, input pins);
endinterface
`default_nettype wire

// File: hdl/hostport_device.sv
/*
 * device end of the parallel host port: data, select, direction, strobe,
 * open-drain request and acknowledge, each pin usable as port b gpio.
 * assumes the host end of hostport_if on the far side and user logic on
 * clk supplying the read bank, mode and gpio controls.
 */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - strobe low, direction high: device drives data
// - strobe low, direction low: data lines input
// - strobe high: data lines released
// - strobe rising edge latches data lines
// - host picks register with three select lines
// - unused host port: pins become gpio
// - reset leaves all host pins gpio inputs
// - request open-drain; gpio bit 13 push-pull
// - acknowledge serves dma and interrupt acknowledge
// - unused acknowledge usable as gpio
// - acknowledge held high when unused; here an unused acknowledge is left as gpio, not forced high
// - host strobe from chip select and enable; here the host end times strobe with its setup, strobe and hold counts
module hostport_device
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pins
    hostport_if.device port,
    // mode controls
    input wire logic host_mode,
    input wire logic ack_func_en,
    // register bank read by the host
    input wire hostport_pkg::bank_t rd_bank,
    // service request to the host
    input wire logic service_req,
    // gpio
    input wire hostport_pkg::pins_t gpio_out,
    input wire hostport_pkg::pins_t gpio_dir,
    output logic [hostport_pkg::PIN_W-1:0] gpio_in,
    // host write and read events
    output logic [hostport_pkg::DATA_W-1:0] wr_data,
    output logic [hostport_pkg::SEL_W-1:0] wr_sel,
    output logic wr_pulse,
    output logic [hostport_pkg::SEL_W-1:0] rd_sel,
    output logic rd_pulse,
    output logic [hostport_pkg::DATA_W-1:0] latch_data,
    // acknowledge seen
    output logic ack_seen
);
    import hostport_pkg::*;

    typedef struct packed {
        pins_t s1;
        pins_t s2;
        logic stb_prev;
        pins_t pin_o;
        pins_t pin_oe;
        pins_t gpio_in;
        byte_t latch;
        byte_t wr_data;
        sel_t wr_sel;
        logic wr_pulse;
        sel_t rd_sel;
        logic rd_pulse;
        logic ack;
    } dev_state_t;

    dev_state_t st_r;
    dev_state_t st_nxt;

    // gpio drive of one pin
    function automatic logic gpio_oe(input pins_t dir, input int idx);
        gpio_oe = dir[idx];
    endfunction

    logic stb_n;
    logic dir_hi;
    sel_t sel;

    always_comb
    begin
        st_nxt = st_r;
        // two-flop synchroniser of every pin
        st_nxt.s1 = port.pins;
        st_nxt.s2 = st_r.s1;
        stb_n = st_r.s2[STB_BIT];
        dir_hi = st_r.s2[DIR_BIT];
        sel = st_r.s2[SEL_LSB +: SEL_W];
        st_nxt.stb_prev = stb_n;
        st_nxt.gpio_in = st_r.s2;
        st_nxt.wr_pulse = 1'b0;
        st_nxt.rd_pulse = 1'b0;
        st_nxt.ack = 1'b0;
        // gpio default for every pin
        for (int i = 0; i < PIN_W; i = i + 1)
        begin
            st_nxt.pin_o[i] = gpio_out[i];
            st_nxt.pin_oe[i] = gpio_oe(gpio_dir, i);
        end
        if (host_mode)
        begin
            // host pins are inputs unless a read is in progress
            for (int i = 0; i <= STB_BIT; i = i + 1)
            begin
                st_nxt.pin_o[i] = 1'b0;
                st_nxt.pin_oe[i] = 1'b0;
            end
            if (!stb_n && dir_hi)
            begin
                st_nxt.pin_o[DATA_LSB +: DATA_W] = rd_bank[sel];
                st_nxt.pin_oe[DATA_LSB +: DATA_W] = 8'hff;
                if (st_r.stb_prev)
                begin
                    // one pulse per read access, select names the register
                    st_nxt.rd_pulse = 1'b1;
                    st_nxt.rd_sel = sel;
                end
            end
            if (stb_n && !st_r.stb_prev)
            begin
                st_nxt.latch = st_r.s2[DATA_LSB +: DATA_W];
                if (!dir_hi)
                begin
                    st_nxt.wr_data = st_r.s2[DATA_LSB +: DATA_W];
                    st_nxt.wr_sel = sel;
                    st_nxt.wr_pulse = 1'b1;
                end
            end
            // request is open drain: pull low only
            st_nxt.pin_o[REQ_BIT] = 1'b0;
            st_nxt.pin_oe[REQ_BIT] = service_req;
            if (ack_func_en)
            begin
                st_nxt.pin_o[ACK_BIT] = 1'b0;
                st_nxt.pin_oe[ACK_BIT] = 1'b0;
                // acknowledge is active low, idles high by pull
                st_nxt.ack = !st_r.s2[ACK_BIT];
            end
            // else acknowledge stays gpio
        end
        // outside host mode request pin is a push-pull gpio
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            st_r.s1 <= PIN_PULL;
            st_r.s2 <= PIN_PULL;
            st_r.stb_prev <= PIN_PULL[STB_BIT];
            st_r.pin_o <= OUT_RESET;
            st_r.pin_oe <= OE_RESET;
            st_r.gpio_in <= PIN_PULL;
            st_r.latch <= DATA_RESET;
            st_r.wr_data <= DATA_RESET;
            st_r.wr_sel <= SEL_RESET;
            st_r.wr_pulse <= 1'b0;
            st_r.rd_sel <= SEL_RESET;
            st_r.rd_pulse <= 1'b0;
            st_r.ack <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state flops
    assign port.dev_o = st_r.pin_o;
    assign port.dev_oe = st_r.pin_oe;
    assign gpio_in = st_r.gpio_in;
    assign wr_data = st_r.wr_data;
    assign wr_sel = st_r.wr_sel;
    assign wr_pulse = st_r.wr_pulse;
    assign rd_sel = st_r.rd_sel;
    assign rd_pulse = st_r.rd_pulse;
    assign latch_data = st_r.latch;
    assign ack_seen = st_r.ack;
endmodule
`default_nettype wire

// File: hdl/hostport_host.sv
/*
 * host end of the parallel host port: runs one register access per command
 * with setup, strobe and hold phases, watches the request line and drives
 * the acknowledge line low on demand.
 * assumes the device end of hostport_if on the far side.
 */
`timescale 1ns/1ps
`default_nettype none
module hostport_host
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pins
    hostport_if.host port,
    // host owns the pins
    input wire logic enable,
    // command
    input wire logic cmd_valid,
    input wire logic cmd_read,
    input wire hostport_pkg::sel_t cmd_sel,
    input wire hostport_pkg::byte_t cmd_wdata,
    output logic cmd_ready,
    // read answer
    output logic rsp_valid,
    output logic [hostport_pkg::DATA_W-1:0] rsp_data,
    // request and acknowledge
    input wire logic ack_assert,
    output logic req_seen
);
    import hostport_pkg::*;

    typedef struct packed {
        host_st_t st;
        logic [3:0] cnt;
        pins_t s1;
        pins_t s2;
        pins_t pin_o;
        pins_t pin_oe;
        logic ready;
        logic rsp_valid;
        byte_t rsp_data;
        logic req;
    } host_state_t;

    host_state_t st_r;
    host_state_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = port.pins;
        st_nxt.s2 = st_r.s1;
        st_nxt.rsp_valid = 1'b0;
        st_nxt.req = !st_r.s2[REQ_BIT];
        // acknowledge pulled low on demand, else left to its pull-up
        st_nxt.pin_o[ACK_BIT] = 1'b0;
        st_nxt.pin_oe[ACK_BIT] = enable && ack_assert;
        unique case (st_r.st)
            st_idle:
            begin
                st_nxt.ready = enable;
                if (cmd_valid && st_r.ready)
                begin
                    st_nxt.ready = 1'b0;
                    st_nxt.pin_o[SEL_LSB +: SEL_W] = cmd_sel;
                    st_nxt.pin_oe[SEL_LSB +: SEL_W] = 3'h7;
                    st_nxt.pin_o[DIR_BIT] = cmd_read;
                    st_nxt.pin_oe[DIR_BIT] = 1'b1;
                    st_nxt.pin_o[STB_BIT] = 1'b1;
                    st_nxt.pin_oe[STB_BIT] = 1'b1;
                    st_nxt.pin_o[DATA_LSB +: DATA_W] = cmd_wdata;
                    st_nxt.pin_oe[DATA_LSB +: DATA_W] =
                        cmd_read ? 8'h00 : 8'hff;
                    st_nxt.cnt = SETUP_CYC - 4'h1;
                    st_nxt.st = st_setup;
                end
            end
            st_setup:
            begin
                st_nxt.cnt = st_r.cnt - 4'h1;
                if (st_r.cnt == CNT_RESET)
                begin
                    // strobe driven low once the setup count runs out
                    st_nxt.pin_o[STB_BIT] = 1'b0;
                    st_nxt.cnt = STROBE_CYC - 4'h1;
                    st_nxt.st = st_strobe;
                end
            end
            st_strobe:
            begin
                // direction and select held
                st_nxt.cnt = st_r.cnt - 4'h1;
                if (st_r.cnt == CNT_RESET)
                begin
                    if (st_r.pin_o[DIR_BIT])
                    begin
                        st_nxt.rsp_valid = 1'b1;
                        st_nxt.rsp_data = st_r.s2[DATA_LSB +: DATA_W];
                    end
                    st_nxt.pin_o[STB_BIT] = 1'b1;
                    st_nxt.cnt = HOLD_CYC - 4'h1;
                    st_nxt.st = st_hold;
                end
            end
            st_hold:
            begin
                st_nxt.cnt = st_r.cnt - 4'h1;
                if (st_r.cnt == CNT_RESET)
                begin
                    st_nxt.pin_oe[STB_BIT:0] = 13'h0000;
                    st_nxt.ready = enable;
                    st_nxt.st = st_idle;
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            st_r.st <= st_idle;
            st_r.cnt <= CNT_RESET;
            st_r.s1 <= PIN_PULL;
            st_r.s2 <= PIN_PULL;
            st_r.pin_o <= OUT_RESET;
            st_r.pin_oe <= OE_RESET;
            st_r.ready <= 1'b0;
            st_r.rsp_valid <= 1'b0;
            st_r.rsp_data <= DATA_RESET;
            st_r.req <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign port.host_o = st_r.pin_o;
    assign port.host_oe = st_r.pin_oe;
    assign cmd_ready = st_r.ready;
    assign rsp_valid = st_r.rsp_valid;
    assign rsp_data = st_r.rsp_data;
    assign req_seen = st_r.req;
endmodule
`default_nettype wire

// File: tb/hostport_props.sv
/*
 * pin checks for the host port.
 * assumes both ends joined by hostport_if.
 */
`timescale 1ns/1ps
`default_nettype none
module hostport_props
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // interface signals
    input wire hostport_pkg::pins_t dev_o,
    input wire hostport_pkg::pins_t dev_oe,
    input wire hostport_pkg::pins_t host_o,
    input wire hostport_pkg::pins_t host_oe,
    input wire hostport_pkg::pins_t pins
);
    import hostport_pkg::*;
    logic on;
    assign on = host_oe[STB_BIT];
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    sequence rd_low;
        on && !pins[STB_BIT] && pins[DIR_BIT];
    endsequence
    sequence stb_high;
        on && pins[STB_BIT];
    endsequence
    a_read_drive: assert property (rd_low [*5] |-> dev_oe[7:0] == 8'hff)
        else $error("data not driven in read");
    a_no_contention: assert property (|dev_oe[7:0] |-> host_oe[7:0] == 8'h00)
        else $error("both ends drive data");
    a_write_input: assert property (on && !pins[STB_BIT] && !pins[DIR_BIT]
        |-> dev_oe[7:0] == 8'h00)
        else $error("data driven in write");
    a_data_released: assert property (stb_high [*4] |-> dev_oe[7:0] == 8'h00)
        else $error("data not released");
    a_reset_inputs: assert property (disable iff (1'b0)
        !resetn |=> dev_oe == 15'h0000)
        else $error("pin driven in reset");
    a_request_od: assert property (on |-> !(dev_oe[REQ_BIT] && dev_o[REQ_BIT]))
        else $error("request driven high");
    a_ack_low: assert property (host_oe[ACK_BIT] |-> !host_o[ACK_BIT])
        else $error("acknowledge driven high");
    a_strobe_len: assert property (on && $fell(pins[STB_BIT])
        |-> !pins[STB_BIT] [*8] ##1 pins[STB_BIT])
        else $error("strobe length wrong");
    a_strobe_sel: assert property (on && !pins[STB_BIT]
        |-> host_oe[11:8] == 4'hf)
        else $error("strobe without select");
    a_sel_stable: assert property ((on && !pins[STB_BIT]) [*2]
        |-> $stable(pins[11:8]))
        else $error("select moved in strobe");
endmodule
`default_nettype wire

// File: tb/host_parallel_port_pins_bench.sv
/*
 * bench for the host port: device and host ends joined by the interface.
 * assumes a 50 mhz clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module host_parallel_port_pins_bench;
    import hostport_pkg::*;
    logic clk, resetn, host_mode, ack_func_en, service_req, enable;
    logic cmd_valid, cmd_read, cmd_ready, rsp_valid, ack_assert, req_seen;
    logic wr_pulse, rd_pulse, ack_seen;
    bank_t rd_bank;
    pins_t gpio_out, gpio_dir, gpio_in;
    byte_t cmd_wdata, wr_data, latch_data, rsp_data;
    sel_t cmd_sel, wr_sel, rd_sel;
    int n_mismatch, total_checks, cycles, n_rd;
    hostport_if hp();
    hostport_device u_hostport_device (.clk(clk), .resetn(resetn),
        .port(hp), .host_mode(host_mode), .ack_func_en(ack_func_en),
        .rd_bank(rd_bank), .service_req(service_req), .gpio_out(gpio_out),
        .gpio_dir(gpio_dir), .gpio_in(gpio_in), .wr_data(wr_data),
        .wr_sel(wr_sel), .wr_pulse(wr_pulse), .rd_sel(rd_sel),
        .rd_pulse(rd_pulse), .latch_data(latch_data), .ack_seen(ack_seen));
    hostport_host u_hostport_host (.clk(clk), .resetn(resetn), .port(hp),
        .enable(enable), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
        .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .ack_assert(ack_assert), .req_seen(req_seen));
    hostport_props u_hostport_props (.clk(clk), .resetn(resetn),
        .dev_o(hp.dev_o), .dev_oe(hp.dev_oe), .host_o(hp.host_o),
        .host_oe(hp.host_oe), .pins(hp.pins));

    task automatic check(input string what, input pins_t exp, input pins_t got);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop;
        if (n_mismatch == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // one host access, returns at the answer or write pulse
    task automatic access(input logic rd, input sel_t sel, input byte_t wd);
        int n;
        @(posedge clk);
        while (cmd_ready !== 1'b1)
            @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_read <= rd;
        cmd_sel <= sel;
        cmd_wdata <= wd;
        @(posedge clk);
        cmd_valid <= 1'b0;
        n = 0;
        while (n < 40 && (rd ? rsp_valid : wr_pulse) !== 1'b1)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic t_write;
        byte_t d;
        for (int i = 0; i < REGS; i++)
        begin
            d = 8'h96 ^ byte_t'(i);
            access(1'b0, sel_t'(i), d);
            check("wr_pulse", 15'h0001, pins_t'(wr_pulse));
            check("wr_data", pins_t'(d), pins_t'(wr_data));
            check("wr_sel", pins_t'(i), pins_t'(wr_sel));
            check("latch_data", pins_t'(d), pins_t'(latch_data));
        end
    endtask

    task automatic t_read;
        n_rd = 0;
        for (int i = 0; i < REGS; i++)
        begin
            access(1'b1, sel_t'(i), 8'h00);
            check("rsp_valid", 15'h0001, pins_t'(rsp_valid));
            check("rsp_data", pins_t'(8'h5a + byte_t'(8'h13 * i)),
                pins_t'(rsp_data));
            check("rd_sel", pins_t'(i), pins_t'(rd_sel));
        end
        repeat (6) @(negedge clk);
        check("data oe", 15'h0000, pins_t'(hp.dev_oe[7:0]));
        check("rd_pulse count", pins_t'(REGS), pins_t'(n_rd));
    endtask

    task automatic t_req_ack;
        @(posedge clk);
        service_req <= 1'b1;
        ack_func_en <= 1'b1;
        ack_assert <= 1'b1;
        repeat (6) @(negedge clk);
        check("req_seen", 15'h0001, pins_t'(req_seen));
        check("ack_seen", 15'h0001, pins_t'(ack_seen));
        @(posedge clk);
        service_req <= 1'b0;
        ack_func_en <= 1'b0;
        repeat (6) @(negedge clk);
        check("req idle", 15'h0000, pins_t'(req_seen));
        check("ack gpio", 15'h0000, pins_t'(ack_seen));
        check("ack pin", 15'h0000, gpio_in & 15'h4000);
    endtask

    task automatic t_gpio;
        @(posedge clk);
        ack_assert <= 1'b0;
        enable <= 1'b0;
        repeat (4) @(posedge clk);
        host_mode <= 1'b0;
        gpio_dir <= 15'h3fff;
        gpio_out <= 15'h2a55;
        repeat (6) @(negedge clk);
        check("gpio pins", 15'h6a55, hp.pins);
        check("gpio_in", 15'h6a55, gpio_in);
        check("req push", 15'h2000, hp.dev_oe & hp.dev_o & 15'h2000);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (rd_pulse === 1'b1)
            n_rd++;
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end

    initial
    begin
        {resetn, ack_func_en, service_req, cmd_valid, cmd_read} = 5'h00;
        {host_mode, enable, ack_assert} = 3'h6;
        {gpio_out, gpio_dir, cmd_sel, cmd_wdata} = 41'h0;
        for (int i = 0; i < REGS; i++)
            rd_bank[i] = 8'h5a + byte_t'(8'h13 * i);
        repeat (2) @(negedge clk);
        check("oe in reset", 15'h0000, hp.dev_oe);
        check("gpio_in", 15'h7000, gpio_in);
        @(posedge clk);
        resetn <= 1'b1;
        t_write();
        t_read();
        t_req_ack();
        t_gpio();
        report_and_stop();
    end
endmodule
`default_nettype wire
